// File: hdl/tcm_cmp_chan.sv
/*
 * One compare channel: buffer stage, active compare register, match
 * detect and the compare output register with its set/clear/toggle logic.
 * Assumes tick is a one-cycle timer clock enable on core_clk.
 */
module tcm_cmp_chan
   import tcm_pkg::*;
#(
   parameter int W = DW
) (
   input  wire logic         core_clk,     // system clock
   input  wire logic         rst_b,        // async reset, active low
   input  wire logic         wr_stb,       // software writes compare value
   input  wire logic [W-1:0] wr_data,      // value written
   input  wire logic         buffered,     // pwm mode: buffer in front
   input  wire logic         reload,       // top or bottom reached
   input  wire logic [W-1:0] count_value,  // present counter value
   input  wire logic         tick,         // timer clock enable
   input  wire logic         blocked,      // counter was just written
   input  wire logic [1:0]   action_sel,   // output action select
   input  wire logic         force_stb,    // force compare strobe
   input  wire logic         toggle_ok,    // pwm toggle allowed
   output logic [W-1:0]      read_value,   // what software reads back
   output logic [W-1:0]      active_value, // value the comparator uses
   output logic              match_hit,    // unblocked match this tick
   output logic              out_reg_q     // compare output register
);
   logic [W-1:0] buf_reg, buf_next, act_reg, act_next;
   logic         out_reg, out_next, nonpwm_evt;

   // writes land in the buffer while buffering, else go straight through
   assign buf_next     = wr_stb ? wr_data : buf_reg;
   assign act_next     = (!buffered && wr_stb) ? wr_data :
                         (buffered && reload)  ? buf_reg : act_reg;
   assign read_value   = buffered ? buf_reg : act_reg;
   assign active_value = act_reg;
   assign match_hit    = tick && !blocked && (count_value == act_reg);
   // a force acts only outside pwm and never reaches the match flag
   assign nonpwm_evt   = !buffered && (match_hit || force_stb);

   // action select is read live, so a new setting acts at the next match
   always_comb begin
      out_next = out_reg;
      if (nonpwm_evt) begin
         unique case (action_sel)
            ACT_NONE:   out_next = out_reg;
            ACT_TOGGLE: out_next = !out_reg;
            ACT_CLEAR:  out_next = 1'b0;
            ACT_SET:    out_next = 1'b1;
         endcase
      end else if (buffered) begin
         unique case (action_sel)
            ACT_NONE:   out_next = out_reg;
            ACT_TOGGLE: out_next = (match_hit && toggle_ok) ? !out_reg : out_reg;
            ACT_CLEAR:  out_next = match_hit ? 1'b0 : (reload ? 1'b1 : out_reg);
            ACT_SET:    out_next = match_hit ? 1'b1 : (reload ? 1'b0 : out_reg);
         endcase
      end
   end

   // mode changes never touch out_reg; reset clears it
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         buf_reg <= REG_RST;
         act_reg <= REG_RST;
         out_reg <= OUT_RST;
      end else begin
         buf_reg <= buf_next;
         act_reg <= act_next;
         out_reg <= out_next;
      end
   end
   assign out_reg_q = out_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   direct_write_a: assert property (
      wr_stb && !buffered |=> act_reg == $past(wr_data))
      else $error("unbuffered compare write not applied");
   force_toggle_a: assert property (
      force_stb && !buffered && action_sel == ACT_TOGGLE |=> out_reg != $past(out_reg))
      else $error("forced toggle did not change output");
   no_action_a: assert property (
      action_sel == ACT_NONE |=> out_reg == $past(out_reg))
      else $error("output changed with no action selected");
endmodule

// File: hdl/tcm_pin_mux.sv
/*
 * Port override for one compare pin: picks compare output or general port
 * value and passes the port direction bit through, both registered.
 * Assumes the port logic supplies value and direction on core_clk.
 */
module tcm_pin_mux
   import tcm_pkg::*;
(
   input  wire logic       core_clk,   // system clock
   input  wire logic       rst_b,      // async reset, active low
   input  wire logic [1:0] action_sel, // output action select
   input  wire logic       cmp_out,    // compare output register
   input  wire logic       port_value, // general port output value
   input  wire logic       dir_out,    // pin direction bit, 1 = output
   output tcm_pin_t        pin         // registered pin drive
);
   logic     override;
   tcm_pin_t pin_next;

   // override follows action select only, never the waveform mode
   assign override       = (action_sel != ACT_NONE);
   assign pin_next.value = override ? cmp_out : port_value;
   assign pin_next.oe_b  = !dir_out;

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) pin <= '{value: OUT_RST, oe_b: 1'b1};
      else        pin <= pin_next;
   end

   override_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      override |=> pin.value == $past(cmp_out) && pin.oe_b == !$past(dir_out))
      else $error("pin override did not follow compare output");
endmodule

// File: hdl/tcm_pkg.sv
/*
 * Package for the 8-bit timer compare block: register indices, field
 * positions, mode and action encodings, reset values and carrier structs.
 * Assumes a single system clock and a plain synchronous register port.
 */
package tcm_pkg;

   localparam int DW     = 8;   // counter and compare width
   localparam int ADDR_W = 3;   // register port address width
   localparam int NCH    = 2;   // compare channels a and b

   // register indices on the plain register port
   localparam logic [ADDR_W-1:0] ADDR_CTRL_A = 3'h0;
   localparam logic [ADDR_W-1:0] ADDR_CTRL_B = 3'h1;
   localparam logic [ADDR_W-1:0] ADDR_COUNT  = 3'h2;
   localparam logic [ADDR_W-1:0] ADDR_CMP_A  = 3'h3;
   localparam logic [ADDR_W-1:0] ADDR_CMP_B  = 3'h4;
   localparam logic [ADDR_W-1:0] ADDR_FLAGS  = 3'h5;

   // control a: mode bits 1:0, action b at 5:4, action a at 7:6
   localparam int CA_MODE_LSB  = 0;
   localparam int CA_ACT_B_LSB = 4;
   localparam int CA_ACT_A_LSB = 6;
   // control b: clock source 2:0, mode bit 2 at 3, force strobes 6 and 7
   localparam int CB_CS_LSB     = 0;
   localparam int CB_MODE2_BIT  = 3;
   localparam int CB_FORCE_LSB  = 6;
   localparam logic [DW-1:0] CB_STORED_MASK = 8'h0F;
   // flags: overflow, match a, match b
   localparam int FLAG_OVF = 0;
   localparam int FLAG_MA  = 1;
   localparam int NFLAG    = 3;

   // waveform mode select encodings
   localparam logic [2:0] MODE_NORMAL    = 3'h0;
   localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
   localparam logic [2:0] MODE_FAST_TOPA = 3'h7;
   localparam logic [2:0] MODE_PWM_MASK  = 3'h1;  // odd modes are pwm
   localparam int         MODE_TOPA_BIT  = 2;     // pwm toggle allowed

   // output action select encodings
   localparam logic [1:0] ACT_NONE   = 2'h0;
   localparam logic [1:0] ACT_TOGGLE = 2'h1;
   localparam logic [1:0] ACT_CLEAR  = 2'h2;
   localparam logic [1:0] ACT_SET    = 2'h3;

   localparam logic [2:0]    CS_STOP   = 3'h0;
   localparam logic [DW-1:0] CNT_MAX   = 8'hFF;
   localparam logic [DW-1:0] CNT_BOT   = 8'h00;
   localparam logic [DW-1:0] REG_RST   = 8'h00;
   localparam logic          OUT_RST   = 1'b0;

   // one register port request
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DW-1:0]     wdata;
      logic              wr;
      logic              rd;
   } tcm_bus_t;

   // one compare pin: value and active-low output enable
   typedef struct packed {
      logic value;
      logic oe_b;
   } tcm_pin_t;

endpackage

// File: hdl/tcm_timer.sv
/*
 * 8-bit timer/counter compare block: counter in normal and clear-on-match
 * modes, two compare channels, overflow and match flags, pin override and
 * a plain register port.
 * Assumes timer_tick comes from the prescaler as a one-cycle enable on
 * core_clk, and that the port logic supplies pin value and direction.
 */
// Summary of operation
// - compare values are buffered in pwm modes, direct in normal and clear-on-match
// - buffered compare value moves to active register at top or bottom only
// - software compare access hits the buffer when buffering, else active register
// - force strobe acts on output per action select outside pwm modes only, no flag, no counter change
// - counter write blocks every compare match in the next timer tick
// - compare output register keeps its value across mode changes
// - action select is unbuffered and acts from the next match
// - reset clears the compare output register to zero
// - nonzero action select puts compare output on pin, direction stays with port
// - pin override depends on action select only, not on mode
// - action select zero leaves compare output unchanged at matches
// - mode bits set counting; action bits pick set, clear, toggle or polarity
// - normal mode counts up, never clears, wraps from ff to 00
// - normal mode sets overflow flag in the tick the counter becomes zero
// - clear-on-match mode clears counter when it matches compare value a
// - clear-on-match mode sets match flag a each time top is reached
// - top is unbuffered; a top below count runs on through ff and 00
// - toggle action in clear-on-match toggles output a on every match
// - output frequency is clock over two times prescale times one plus top
// - clear-on-match mode sets overflow flag when counter passes ff to 00, except when top is ff
// - match sets its flag one core_clk cycle later; ack or written one clears it
// - counter write beats any clear or count in the same cycle
// - clock source zero stops the counter, software access stays open
module tcm_timer
   import tcm_pkg::*;
#(
   parameter int W = DW
) (
   input  wire logic               core_clk,       // system clock, 50 MHz
   input  wire logic               rst_b,          // async reset, active low
   input  wire tcm_pkg::tcm_bus_t  bus,            // register port request
   output logic [W-1:0]            rd_data,        // read data, one cycle late
   input  wire logic               timer_tick,     // prescaler enable pulse
   input  wire logic [NFLAG-1:0]   flag_ack,       // interrupt serviced, per flag
   input  wire logic [NCH-1:0]     port_value,     // general port output values
   input  wire logic [NCH-1:0]     compare_pin_direction_bit, // 1 = output
   output tcm_pkg::tcm_pin_t [NCH-1:0] compare_pin, // pin drive, a is index 0
   output logic [NFLAG-1:0]        flag_q          // overflow, match a, match b
);
   import tcm_pkg::*;

   // software-visible control state
   logic [W-1:0]       ctrl_a_reg, ctrl_a_next;
   logic [W-1:0]       ctrl_b_reg, ctrl_b_next;
   logic [W-1:0]       counter_value_reg, counter_value_next;
   logic [NFLAG-1:0]   flag_reg, flag_next;
   logic [W-1:0]       rd_data_reg, rd_data_next;
   logic               block_reg, block_next;

   // decoded fields
   logic [2:0]         waveform_mode_select;
   logic [2:0]         clock_source_select;
   logic [1:0]         output_action_select [NCH];
   logic [NCH-1:0]     force_compare_strobe;
   logic               pwm_mode, clear_on_match_mode, top_is_a, toggle_ok;

   // register port decode
   logic               wr_ctrl_a, wr_ctrl_b, wr_count, wr_flags;
   logic [NCH-1:0]     wr_cmp;
   logic [W-1:0]       rd_mux;

   // counter control
   logic               tick, at_max, top_clear, wrap_evt, ovf_set;
   logic [NCH-1:0]     match_hit, cmp_out;
   logic [W-1:0]       cmp_read [NCH];
   logic [W-1:0]       cmp_active [NCH];
   logic [NFLAG-1:0]   flag_set, flag_clr;

   // write strobes per register
   assign wr_ctrl_a = bus.wr && (bus.addr == ADDR_CTRL_A);
   assign wr_ctrl_b = bus.wr && (bus.addr == ADDR_CTRL_B);
   assign wr_count  = bus.wr && (bus.addr == ADDR_COUNT);
   assign wr_flags  = bus.wr && (bus.addr == ADDR_FLAGS);
   assign wr_cmp[0] = bus.wr && (bus.addr == ADDR_CMP_A);
   assign wr_cmp[1] = bus.wr && (bus.addr == ADDR_CMP_B);

   // force bits are strobes only; they are never stored
   assign ctrl_a_next = wr_ctrl_a ? bus.wdata : ctrl_a_reg;
   assign ctrl_b_next = wr_ctrl_b ? (bus.wdata & CB_STORED_MASK) : ctrl_b_reg;
   assign force_compare_strobe = wr_ctrl_b ? bus.wdata[CB_FORCE_LSB +: NCH] : '0;

   // mode and action fields out of the control registers
   assign waveform_mode_select = {ctrl_b_reg[CB_MODE2_BIT], ctrl_a_reg[CA_MODE_LSB +: 2]};
   assign clock_source_select  = ctrl_b_reg[CB_CS_LSB +: 3];
   assign output_action_select[0] = ctrl_a_reg[CA_ACT_A_LSB +: 2];
   assign output_action_select[1] = ctrl_a_reg[CA_ACT_B_LSB +: 2];

   // mode bits alone pick the counting sequence; action bits never do
   assign pwm_mode            = |(waveform_mode_select & MODE_PWM_MASK);
   assign clear_on_match_mode = (waveform_mode_select == MODE_CLR_MATCH);
   assign top_is_a            = clear_on_match_mode ||
                                (waveform_mode_select == MODE_FAST_TOPA);
   assign toggle_ok           = waveform_mode_select[MODE_TOPA_BIT];

   // the timer clock is a gated enable, dead while no source is selected
   assign tick = timer_tick && (clock_source_select != CS_STOP);

   // top clear uses the active compare a in clear-on-match and fast top-a modes, live and unbuffered in
   // clear-on-match; a top written below the count simply misses and the counter runs on to max and wraps
   assign at_max    = (counter_value_reg == CNT_MAX);
   // clearing at top sets the output period: two times prescale times top+1
   assign top_clear = top_is_a && match_hit[0];
   assign wrap_evt  = !wr_count && tick && (top_clear || at_max);

   // overflow when the count passes max to zero; a top clear is not one
   assign ovf_set = !wr_count && tick && at_max && !top_clear;

   // a software write wins over clear and count in the same cycle
   always_comb begin
      counter_value_next = counter_value_reg;
      if (wr_count) begin
         counter_value_next = bus.wdata;
      end else if (tick) begin
         if (top_clear) begin
            counter_value_next = CNT_BOT;
         end else begin
            counter_value_next = counter_value_reg + 8'h01;
         end
      end
   end

   // blocking lasts until the next tick, however long the clock is stopped
   assign block_next = wr_count ? 1'b1 : (tick ? 1'b0 : block_reg);

   // flag set and clear terms; a set in the clearing cycle survives
   assign flag_set[FLAG_OVF]       = ovf_set;
   assign flag_set[FLAG_MA +: NCH] = match_hit;
   assign flag_clr  = flag_ack | (wr_flags ? bus.wdata[NFLAG-1:0] : '0);
   assign flag_next = flag_set | (flag_reg & ~flag_clr);

   // read mux; unmapped addresses read zero
   always_comb begin
      rd_mux = REG_RST;
      unique case (bus.addr)
         ADDR_CTRL_A: rd_mux = ctrl_a_reg;
         ADDR_CTRL_B: rd_mux = ctrl_b_reg;
         ADDR_COUNT:  rd_mux = counter_value_reg;
         ADDR_CMP_A:  rd_mux = cmp_read[0];
         ADDR_CMP_B:  rd_mux = cmp_read[1];
         ADDR_FLAGS:  rd_mux = {{(W-NFLAG){1'b0}}, flag_reg};
         default:     rd_mux = REG_RST;
      endcase
   end
   // read data stands only in the cycle after the strobe
   assign rd_data_next = bus.rd ? rd_mux : REG_RST;

   // control and state registers
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         ctrl_a_reg        <= REG_RST;
         ctrl_b_reg        <= REG_RST;
         counter_value_reg <= REG_RST;
         flag_reg          <= '0;
         rd_data_reg       <= REG_RST;
         block_reg         <= 1'b0;
      end else begin
         ctrl_a_reg        <= ctrl_a_next;
         ctrl_b_reg        <= ctrl_b_next;
         counter_value_reg <= counter_value_next;
         flag_reg          <= flag_next;
         rd_data_reg       <= rd_data_next;
         block_reg         <= block_next;
      end
   end
   assign rd_data = rd_data_reg;
   assign flag_q  = flag_reg;

   // one compare channel and one pin override per output
   for (genvar ch = 0; ch < NCH; ch++) begin : g_chan
      tcm_cmp_chan #(.W(W)) u_chan (
         .core_clk     (core_clk),
         .rst_b        (rst_b),
         .wr_stb       (wr_cmp[ch]),
         .wr_data      (bus.wdata),
         .buffered     (pwm_mode),
         .reload       (wrap_evt),
         .count_value  (counter_value_reg),
         .tick         (tick),
         .blocked      (block_reg),
         .action_sel   (output_action_select[ch]),
         .force_stb    (force_compare_strobe[ch]),
         .toggle_ok    (toggle_ok && (ch == 0)),
         .read_value   (cmp_read[ch]),
         .active_value (cmp_active[ch]),
         .match_hit    (match_hit[ch]),
         .out_reg_q    (cmp_out[ch])
      );
      tcm_pin_mux u_pin (
         .core_clk   (core_clk),
         .rst_b      (rst_b),
         .action_sel (output_action_select[ch]),
         .cmp_out    (cmp_out[ch]),
         .port_value (port_value[ch]),
         .dir_out    (compare_pin_direction_bit[ch]),
         .pin        (compare_pin[ch])
      );
   end

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);

   // a counter write followed by the first tick that would match a
   sequence count_written;
      wr_count;
   endsequence
   sequence first_tick_on_a;
      tick && !wr_count && counter_value_reg == cmp_active[0] && !flag_reg[FLAG_MA];
   endsequence

   normal_wrap_a: assert property (
      waveform_mode_select == MODE_NORMAL && tick && !wr_count && at_max
      |=> counter_value_reg == CNT_BOT && flag_reg[FLAG_OVF])
      else $error("normal mode wrap did not raise overflow");
   write_wins_a: assert property (
      wr_count |=> counter_value_reg == $past(bus.wdata))
      else $error("counter write lost to count or clear");
   stopped_hold_a: assert property (
      clock_source_select == CS_STOP && !wr_count |=> $stable(counter_value_reg))
      else $error("counter moved with clock source stopped");
   match_block_a: assert property (
      count_written ##1 (first_tick_on_a and (!flag_ack[FLAG_MA]))
      |=> !flag_reg[FLAG_MA])
      else $error("match not blocked after counter write");
   top_clear_a: assert property (
      clear_on_match_mode && tick && !wr_count && !block_reg
      && counter_value_reg == cmp_active[0]
      |=> counter_value_reg == CNT_BOT && flag_reg[FLAG_MA])
      else $error("clear-on-match did not clear and flag");
   ctc_overflow_a: assert property (
      clear_on_match_mode && tick && !wr_count && at_max && cmp_active[0] != CNT_MAX
      |=> counter_value_reg == CNT_BOT ##0 flag_reg[FLAG_OVF])
      else $error("clear-on-match max wrap missed overflow");
   flag_set_wins_a: assert property (
      ovf_set && flag_clr[FLAG_OVF] |=> flag_reg[FLAG_OVF])
      else $error("overflow set lost to simultaneous clear");
   read_once_a: assert property (
      bus.rd |=> rd_data == $past(rd_mux) ##1 (bus.rd || $past(bus.rd) || rd_data == REG_RST))
      else $error("read data wrong or held too long");
endmodule

// File: verif/tcm_port_model.sv
/*
 * Port pin model: general port value and direction bits, and the pad level.
 * Assumes the timer registers its pin drive on core_clk.
 */
module tcm_port_model
   import tcm_pkg::*;
(
   input  wire logic                        core_clk,   // system clock
   input  wire logic [NCH-1:0]              dir_req,    // wanted direction
   input  wire logic [NCH-1:0]              val_req,    // wanted port value
   input  wire tcm_pkg::tcm_pin_t [NCH-1:0] pin,        // timer pin drive
   output logic [NCH-1:0]                   port_value, // general port value
   output logic [NCH-1:0]                   dir_bit,    // direction, 1 = output
   output logic [NCH-1:0]                   pad         // resolved pad level
);
   // port registers start cleared so the timer never sees unknowns
   initial begin
      port_value = '0;
      dir_bit = '0;
   end
   // port registers follow software one cycle late
   always @(posedge core_clk) begin
      port_value <= val_req;
      dir_bit <= dir_req;
   end
   // undriven pad floats high through the pull-up
   always_comb begin
      for (int i = 0; i < NCH; i++) pad[i] = pin[i].oe_b ? 1'b1 : pin[i].value;
   end
endmodule

// File: verif/tcm_timer_bench.sv
/*
 * Self-checking bench for the timer compare block.
 * Assumes the port model beside it and a bench-made timer tick.
 */
module tcm_timer_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import tcm_pkg::*;
   logic               core_clk = 1'b0;
   logic               rst_b = 1'b0;
   tcm_bus_t           bus = '0;
   logic               timer_tick = 1'b0;
   logic [NCH-1:0]     dir_req = '0;
   logic [NCH-1:0]     val_req = '0;
   logic [NFLAG-1:0]   flag_ack = '0;
   logic [DW-1:0]      rd_data;
   logic [NCH-1:0]     port_value;
   logic [NCH-1:0]     dir_bit;
   logic [NCH-1:0]     pad;
   tcm_pin_t [NCH-1:0] pin;
   logic [NFLAG-1:0]   flag_q;
   logic [DW-1:0]      d;
   int                 mismatches = 0;
   int                 tests_run = 0;

   tcm_timer #(.W(DW)) dut (.core_clk(core_clk), .rst_b(rst_b), .bus(bus), .rd_data(rd_data),
      .timer_tick(timer_tick), .flag_ack(flag_ack), .port_value(port_value),
      .compare_pin_direction_bit(dir_bit), .compare_pin(pin), .flag_q(flag_q));
   tcm_port_model model (.core_clk(core_clk), .dir_req(dir_req), .val_req(val_req), .pin(pin),
      .port_value(port_value), .dir_bit(dir_bit), .pad(pad));

   // 50 MHz system clock
   always #10 core_clk = ~core_clk;

   task check(input logic [7:0] seen, input logic [7:0] exp);
      tests_run++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wr(input logic [2:0] a, input logic [7:0] v);
      @(posedge core_clk) bus <= '{a, v, 1'b1, 1'b0};
      @(posedge core_clk) bus.wr <= 1'b0;
   endtask
   // read data stands only in the cycle after the strobe
   task rd(input logic [2:0] a);
      @(posedge core_clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
      @(posedge core_clk) bus.rd <= 1'b0;
      @(negedge core_clk) d = rd_data;
   endtask
   task ticks(input int n);
      @(posedge core_clk) timer_tick <= 1'b1;
      repeat (n - 1) @(posedge core_clk);
      @(posedge core_clk) timer_tick <= 1'b0;
   endtask
   task settle;
      repeat (3) @(negedge core_clk);
   endtask
   task results;
      $display("mismatches %0d tests_run %0d", mismatches, tests_run);
      if (mismatches == 0 && tests_run > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask

   task t_reset;
      check({5'h00, flag_q}, 8'h00);
      check({6'h00, pin[0]}, 8'h01);
      rd(ADDR_COUNT);
      check(d, 8'h00);
   endtask
   // output set by force before the pin is made an output
   task t_force;
      wr(ADDR_CTRL_A, 8'hC0);
      wr(ADDR_CTRL_B, 8'h41);
      settle;
      check({7'h00, pin[0].value}, 8'h01);
      check({5'h00, flag_q}, 8'h00);
      rd(ADDR_COUNT);
      check(d, 8'h00);
      @(posedge core_clk) dir_req <= 2'b01;
      settle;
      check({6'h00, pin[0]}, 8'h02);
      check({7'h00, pad[0]}, 8'h01);
   endtask
   task t_ctc;
      wr(ADDR_CMP_A, 8'h03);
      wr(ADDR_CTRL_A, 8'h42);
      settle;
      check({7'h00, pin[0].value}, 8'h01);
      wr(ADDR_COUNT, 8'h00);
      ticks(4);
      settle;
      rd(ADDR_COUNT);
      check(d, 8'h00);
      check({5'h00, flag_q}, 8'h02);
      check({7'h00, pad[0]}, 8'h00);
   endtask
   task t_ovf_block;
      wr(ADDR_FLAGS, 8'h07);
      wr(ADDR_CTRL_A, 8'h00);
      val_req <= 2'b01;
      wr(ADDR_COUNT, 8'h03);
      ticks(1);
      settle;
      check({5'h00, flag_q}, 8'h00);
      check({7'h00, pad[0]}, 8'h01);
      wr(ADDR_COUNT, 8'hFE);
      ticks(2);
      settle;
      check({5'h00, flag_q}, 8'h01);
      rd(ADDR_COUNT);
      check(d, 8'h00);
      // serviced interrupt clears the overflow flag
      @(posedge core_clk) flag_ack <= 3'h1;
      @(posedge core_clk) flag_ack <= 3'h0;
      settle;
      check({5'h00, flag_q}, 8'h00);
   endtask

   // main sequence: reset held 16 cycles, then the scenarios
   initial begin
      repeat (16) @(posedge core_clk);
      rst_b <= 1'b1;
      settle;
      t_reset;
      t_force;
      t_ctc;
      t_ovf_block;
      results;
   end
   // watchdog well beyond the hundred or so cycles the run needs
   initial begin
      #100us;
      mismatches++;
      results;
   end
endmodule
